//--- shared/sensor_i2c_pkg.sv
// Constants and types shared by the sensor two-wire command port
package sensor_i2c_pkg;

   // Slave address: six fixed bits, then the inverted select pin level
   localparam logic [5:0]  ADDR_PREFIX      = 6'h3b;

   // Command byte encodings
   localparam logic [7:0]  CMD_RESET        = 8'h1e;
   localparam logic [7:0]  CMD_ADC_READ     = 8'h00;
   localparam logic [3:0]  CMD_PROM_HI      = 4'ha;
   localparam logic [2:0]  CMD_CONV_HI      = 3'h2;
   localparam logic [2:0]  OSR_IDX_MAX      = 3'h4;

   // Widths and counts
   localparam int          RESULT_W         = 24;
   localparam int          PROM_W           = 16;
   localparam int          PROM_WORDS       = 8;
   localparam int          CONV_BASE_CYCLES = 256;

   // Bit slot positions within one byte frame
   localparam logic [3:0]  BIT_FIRST        = 4'h1;
   localparam logic [3:0]  BYTE_LAST        = 4'h7;
   localparam logic [3:0]  ACK_SLOT         = 4'h8;

   // Values after reset and fill patterns
   localparam logic [3:0]  BIT_CNT_RESET    = 4'h0;
   localparam logic [23:0] WORD_RESET       = 24'h000000;
   localparam logic [7:0]  FILL_BYTE        = 8'hff;
   localparam logic [23:0] CORRUPT_MASK     = 24'h5a5a5a;

   typedef enum logic [1:0] {
      PH_ADDR,
      PH_WRITE,
      PH_READ,
      PH_IGNORE
   } phase_t;

   typedef struct packed {
      logic       is_temp;
      logic [2:0] osr_idx;
   } conv_sel_t;

   typedef struct packed {
      logic [23:0] pressure;
      logic [23:0] temperature;
   } sample_t;

endpackage

//--- rtl/sensor_i2c_command_port.sv
// Two-wire slave command port of a pressure and temperature sensor
`timescale 1ns/10ps

module sensor_i2c_command_port #(
   parameter int unsigned CONV_BASE_CYCLES = sensor_i2c_pkg::CONV_BASE_CYCLES
) (
   // Core clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    resetn,
   // Two-wire bus, clock from the master
   input  wire logic                    scl,
   input  wire logic                    sda_in,
   output logic                         sda_out,
   output logic                         sda_oe,
   // Address select pin
   input  wire logic                    address_select_pin,
   // Converter samples and calibration memory image
   input  wire sensor_i2c_pkg::sample_t samples,
   input  wire logic [127:0]            prom_image,
   // Status
   output logic                         conv_busy
);

   localparam logic [15:0] BASE16 = 16'(CONV_BASE_CYCLES);

   // ---------------- Start and stop detection on data edges
   logic start_tog_r;
   logic stop_tog_r;

   always_ff @(negedge sda_in or negedge resetn) begin
      if (!resetn) begin
         start_tog_r <= 1'b0;
      end else if (scl) begin
         start_tog_r <= ~start_tog_r;
      end
   end

   always_ff @(posedge sda_in or negedge resetn) begin
      if (!resetn) begin
         stop_tog_r <= 1'b0;
      end else if (scl) begin
         stop_tog_r <= ~stop_tog_r;
      end
   end

   // ---------------- Link side, clocked by the bus clock
   sensor_i2c_pkg::phase_t phase_r, phase_nxt;
   logic [3:0]  bit_cnt_r, bit_cnt_nxt;
   logic [7:0]  rx_sh_r;
   logic [7:0]  cmd_byte_r, cmd_byte_nxt;
   logic [23:0] tx_sh_r, tx_sh_nxt;
   logic [23:0] rd_word_r;
   logic        ack_pend_r, ack_pend_nxt;
   logic        cmd_tog_r, cmd_tog_nxt;
   logic        take_tog_r, take_tog_nxt;
   logic        start_seen_r;
   logic        csb_meta_r;
   logic        csb_sync_r;
   logic        sda_oe_r;

   wire         new_frame = start_tog_r != start_seen_r;
   wire  [7:0]  rx_byte   = {rx_sh_r[6:0], sda_in};
   wire         ack_slot  = bit_cnt_r == sensor_i2c_pkg::ACK_SLOT;
   wire         byte_done = !new_frame &&
                            bit_cnt_r == sensor_i2c_pkg::BYTE_LAST;
   wire  [6:0]  own_addr  = {sensor_i2c_pkg::ADDR_PREFIX, ~csb_sync_r};
   wire         addr_hit  = byte_done && phase_r == sensor_i2c_pkg::PH_ADDR
                            && rx_byte[7:1] == own_addr;
   wire         rd_nack   = !new_frame && ack_slot && sda_in &&
                            phase_r == sensor_i2c_pkg::PH_READ;
   wire         drive_nxt = (ack_slot && ack_pend_r) ||
                            (phase_r == sensor_i2c_pkg::PH_READ &&
                             !ack_slot && !tx_sh_r[23]);

   always_comb begin
      phase_nxt    = phase_r;
      bit_cnt_nxt  = bit_cnt_r;
      tx_sh_nxt    = tx_sh_r;
      ack_pend_nxt = 1'b0;
      cmd_byte_nxt = cmd_byte_r;
      cmd_tog_nxt  = cmd_tog_r;
      take_tog_nxt = take_tog_r;
      if (new_frame) begin
         phase_nxt   = sensor_i2c_pkg::PH_ADDR;
         bit_cnt_nxt = sensor_i2c_pkg::BIT_FIRST;
      end else if (ack_slot) begin
         bit_cnt_nxt = sensor_i2c_pkg::BIT_CNT_RESET;
         if (rd_nack) begin
            phase_nxt = sensor_i2c_pkg::PH_IGNORE;
         end
      end else begin
         bit_cnt_nxt = bit_cnt_r + 4'h1;
         if (phase_r == sensor_i2c_pkg::PH_READ) begin
            tx_sh_nxt = {tx_sh_r[22:0], 1'b1};
         end
         if (byte_done) begin
            unique case (phase_r)
               sensor_i2c_pkg::PH_ADDR: begin
                  if (addr_hit && rx_byte[0]) begin
                     ack_pend_nxt = 1'b1;
                     phase_nxt    = sensor_i2c_pkg::PH_READ;
                     tx_sh_nxt    = rd_word_r;
                     take_tog_nxt = ~take_tog_r;
                  end else if (addr_hit) begin
                     ack_pend_nxt = 1'b1;
                     phase_nxt    = sensor_i2c_pkg::PH_WRITE;
                  end else begin
                     phase_nxt    = sensor_i2c_pkg::PH_IGNORE;
                  end
               end
               sensor_i2c_pkg::PH_WRITE: begin
                  ack_pend_nxt = 1'b1;
                  cmd_byte_nxt = rx_byte;
                  cmd_tog_nxt  = ~cmd_tog_r;
               end
               sensor_i2c_pkg::PH_READ: begin
               end
               sensor_i2c_pkg::PH_IGNORE: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge scl or negedge resetn) begin
      if (!resetn) begin
         phase_r      <= sensor_i2c_pkg::PH_IGNORE;
         bit_cnt_r    <= sensor_i2c_pkg::BIT_CNT_RESET;
         rx_sh_r      <= 8'h00;
         tx_sh_r      <= sensor_i2c_pkg::WORD_RESET;
         ack_pend_r   <= 1'b0;
         cmd_byte_r   <= 8'h00;
         cmd_tog_r    <= 1'b0;
         take_tog_r   <= 1'b0;
         start_seen_r <= 1'b0;
         csb_meta_r   <= 1'b0;
         csb_sync_r   <= 1'b0;
      end else begin
         phase_r      <= phase_nxt;
         bit_cnt_r    <= bit_cnt_nxt;
         rx_sh_r      <= rx_byte;
         tx_sh_r      <= tx_sh_nxt;
         ack_pend_r   <= ack_pend_nxt;
         cmd_byte_r   <= cmd_byte_nxt;
         cmd_tog_r    <= cmd_tog_nxt;
         take_tog_r   <= take_tog_nxt;
         start_seen_r <= start_tog_r;
         csb_meta_r   <= address_select_pin;
         csb_sync_r   <= csb_meta_r;
      end
   end

   // Data line changes only while the clock is low
   always_ff @(negedge scl or negedge resetn) begin
      if (!resetn) begin
         sda_oe_r <= 1'b0;
      end else begin
         sda_oe_r <= drive_nxt;
      end
   end

   assign sda_oe  = sda_oe_r;
   assign sda_out = 1'b0;

   // ---------------- Crossing of link events into the core domain
   logic [2:0] ev_meta_r;
   logic [2:0] ev_sync_r;
   logic [2:0] ev_seen_r;
   wire  [2:0] ev_tog = {take_tog_r, stop_tog_r, cmd_tog_r};
   wire  [2:0] ev     = ev_sync_r ^ ev_seen_r;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ev_meta_r <= 3'h0;
         ev_sync_r <= 3'h0;
         ev_seen_r <= 3'h0;
      end else begin
         ev_meta_r <= ev_tog;
         ev_sync_r <= ev_meta_r;
         ev_seen_r <= ev_sync_r;
      end
   end

   // ---------------- Core: command execution at end of frame
   logic [7:0]  cmd_hold_r;
   logic        cmd_pend_r;
   logic        busy_r, busy_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   sensor_i2c_pkg::conv_sel_t sel_r, sel_nxt;
   logic        corrupt_r, corrupt_nxt;
   logic [23:0] res_r, res_nxt;
   logic        res_valid_r, res_valid_nxt;
   logic [23:0] rd_word_nxt;
   logic        rd_is_adc_r, rd_is_adc_nxt;
   logic        prom_loaded_r;
   logic [15:0] prom_r [sensor_i2c_pkg::PROM_WORDS];

   wire         cmd_ev     = ev[0];
   wire         stop_ev    = ev[1];
   wire         take_ev    = ev[2];
   wire  [7:0]  exec_byte  = cmd_ev ? cmd_byte_r : cmd_hold_r;
   wire         exec       = stop_ev && (cmd_pend_r || cmd_ev);
   wire         exec_reset = exec &&
                             exec_byte == sensor_i2c_pkg::CMD_RESET;
   wire         exec_read  = exec &&
                             exec_byte == sensor_i2c_pkg::CMD_ADC_READ;
   wire         exec_prom  = exec && !exec_byte[0] &&
                             exec_byte[7:4] == sensor_i2c_pkg::CMD_PROM_HI;
   wire         exec_conv  = exec && !exec_byte[0] &&
                             exec_byte[7:5] == sensor_i2c_pkg::CMD_CONV_HI &&
                             exec_byte[3:1] <= sensor_i2c_pkg::OSR_IDX_MAX;
   wire  [15:0] conv_len   = BASE16 << exec_byte[3:1];
   wire  [15:0] prom_word  = prom_r[exec_byte[3:1]];
   wire         conv_done  = busy_r && cnt_r == 16'h0000;
   wire  [23:0] raw_sample = sel_r.is_temp ? samples.temperature
                                           : samples.pressure;
   wire  [23:0] bad_mask   = corrupt_r ? sensor_i2c_pkg::CORRUPT_MASK
                                       : sensor_i2c_pkg::WORD_RESET;

   always_comb begin
      busy_nxt      = busy_r;
      cnt_nxt       = busy_r ? cnt_r - 16'h0001 : cnt_r;
      sel_nxt       = sel_r;
      corrupt_nxt   = corrupt_r;
      res_nxt       = res_r;
      res_valid_nxt = res_valid_r;
      rd_word_nxt   = rd_word_r;
      rd_is_adc_nxt = rd_is_adc_r;
      if (conv_done) begin
         busy_nxt      = 1'b0;
         res_nxt       = raw_sample ^ bad_mask;
         res_valid_nxt = 1'b1;
         corrupt_nxt   = 1'b0;
      end
      if (take_ev && rd_is_adc_r) begin
         rd_word_nxt = sensor_i2c_pkg::WORD_RESET;
      end
      if (exec_reset) begin
         busy_nxt      = 1'b0;
         corrupt_nxt   = 1'b0;
         res_valid_nxt = 1'b0;
         rd_word_nxt   = sensor_i2c_pkg::WORD_RESET;
      end else if (exec_conv) begin
         busy_nxt      = 1'b1;
         cnt_nxt       = conv_len - 16'h0001;
         sel_nxt       = '{is_temp: exec_byte[4], osr_idx: exec_byte[3:1]};
         corrupt_nxt   = busy_r;
         res_valid_nxt = 1'b0;
      end else if (exec_read) begin
         rd_word_nxt   = (res_valid_nxt && !busy_nxt) ? res_nxt
                         : sensor_i2c_pkg::WORD_RESET;
         rd_is_adc_nxt = 1'b1;
         res_valid_nxt = 1'b0;
         corrupt_nxt   = corrupt_nxt || busy_nxt;
      end else if (exec_prom) begin
         rd_word_nxt   = {prom_word, sensor_i2c_pkg::FILL_BYTE};
         rd_is_adc_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cmd_hold_r  <= 8'h00;
         cmd_pend_r  <= 1'b0;
         busy_r      <= 1'b0;
         cnt_r       <= 16'h0000;
         sel_r       <= '0;
         corrupt_r   <= 1'b0;
         res_r       <= sensor_i2c_pkg::WORD_RESET;
         res_valid_r <= 1'b0;
         rd_word_r   <= sensor_i2c_pkg::WORD_RESET;
         rd_is_adc_r <= 1'b0;
      end else begin
         if (cmd_ev) begin
            cmd_hold_r <= cmd_byte_r;
         end
         cmd_pend_r  <= (cmd_ev || cmd_pend_r) && !stop_ev;
         busy_r      <= busy_nxt;
         cnt_r       <= cnt_nxt;
         sel_r       <= sel_nxt;
         corrupt_r   <= corrupt_nxt;
         res_r       <= res_nxt;
         res_valid_r <= res_valid_nxt;
         rd_word_r   <= rd_word_nxt;
         rd_is_adc_r <= rd_is_adc_nxt;
      end
   end

   // Calibration memory is loaded once after reset and on reset commands
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prom_loaded_r <= 1'b0;
      end else begin
         prom_loaded_r <= 1'b1;
      end
   end

   for (genvar i = 0; i < sensor_i2c_pkg::PROM_WORDS; i++) begin : g_prom
      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            prom_r[i] <= 16'h0000;
         end else if (!prom_loaded_r || exec_reset) begin
            prom_r[i] <= prom_image[i*16 +: 16];
         end
      end
   end

   assign conv_busy = busy_r;

   // ---------------- Checks
   sequence s_conv_cmd;
      exec_conv;
   endsequence

   sequence s_busy_run;
      busy_r [*4];
   endsequence

   a_conv_busy_hold: assert property (
      @(posedge core_clk) disable iff (!resetn)
      s_conv_cmd |=> s_busy_run)
      else $error("conversion did not stay busy");

   a_done_gives_result: assert property (
      @(posedge core_clk) disable iff (!resetn)
      conv_done && !exec |=> res_valid_r && !busy_r)
      else $error("finished conversion left no result");

   a_busy_read_zero: assert property (
      @(posedge core_clk) disable iff (!resetn)
      exec_read && busy_r && !conv_done |=> rd_word_r == 24'h000000
      && corrupt_r)
      else $error("read during conversion not zero");

   a_empty_read_zero: assert property (
      @(posedge core_clk) disable iff (!resetn)
      exec_read && !res_valid_r && !conv_done |=> rd_word_r == 24'h000000)
      else $error("read without result not zero");

   a_reset_cmd_idle: assert property (
      @(posedge core_clk) disable iff (!resetn)
      exec_reset |=> !busy_r && !res_valid_r && rd_word_r == 24'h000000)
      else $error("reset command did not clear state");

   a_prom_word_sel: assert property (
      @(posedge core_clk) disable iff (!resetn)
      exec_prom && !exec_reset |=> rd_word_r[23:8] == $past(prom_word))
      else $error("memory word not selected");

   a_addr_ack: assert property (
      @(posedge scl) disable iff (!resetn)
      addr_hit |=> ack_pend_r && bit_cnt_r == 4'h8)
      else $error("own address not acknowledged");

   a_foreign_release: assert property (
      @(posedge scl) disable iff (!resetn)
      byte_done && phase_r == sensor_i2c_pkg::PH_ADDR && !addr_hit
      |=> phase_r == sensor_i2c_pkg::PH_IGNORE && !sda_oe_r)
      else $error("foreign address not ignored");

   a_cmd_ack_capture: assert property (
      @(posedge scl) disable iff (!resetn)
      byte_done && phase_r == sensor_i2c_pkg::PH_WRITE
      |=> ack_pend_r && cmd_byte_r == $past(rx_byte))
      else $error("command byte not captured");

   a_nack_release: assert property (
      @(posedge scl) disable iff (!resetn)
      rd_nack |=> phase_r == sensor_i2c_pkg::PH_IGNORE)
      else $error("master nack did not end read");

   a_read_load_msb: assert property (
      @(posedge scl) disable iff (!resetn)
      addr_hit && rx_byte[0] |=> tx_sh_r == $past(rd_word_r)
      && phase_r == sensor_i2c_pkg::PH_READ)
      else $error("read word not loaded");

endmodule // sensor_i2c_command_port

//--- tb/bus_master_model.sv
// Behavioural two-wire bus master that frames commands and reads
`timescale 1ns/10ps
module bus_master_model (
   // Bus wires
   output logic       scl,
   input  wire logic  sda,
   output logic       sda_low,
   // Observed ack bits and read bytes
   output logic [8:0] res,
   output logic       res_valid
);
   initial begin
      scl       = 1'b1;
      sda_low   = 1'b0;
      res       = 9'h000;
      res_valid = 1'b0;
   end

   // Clock stands still between frames; half period 32 ns
   task automatic xfer(input logic b, output logic s);
      #16 sda_low = ~b;
      #16 scl = 1'b1;
      #16 s = sda;
      #16 scl = 1'b0;
   endtask

   task automatic report(input logic [8:0] v);
      res       = v;
      res_valid = 1'b1;
      #1 res_valid = 1'b0;
   endtask

   task automatic start();
      sda_low = 1'b0;
      scl     = 1'b1;
      #16 sda_low = 1'b1;
      #16 scl = 1'b0;
   endtask

   // Gap after stop lets the command settle before the next frame
   task automatic stop();
      #16 sda_low = 1'b1;
      #16 scl = 1'b1;
      #16 sda_low = 1'b0;
      #300;
   endtask

   task automatic put_byte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer(d[i], s);
      end
      xfer(1'b1, s);
      report({1'b1, 7'h00, s});
   endtask

   task automatic get_byte(input logic last);
      logic [7:0] d;
      logic       s;
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, s);
         d = {d[6:0], s};
      end
      xfer(last, s);
      report({1'b0, d});
   endtask

   // Free a stuck data line: spare clocks, then a stop
   task automatic recover();
      logic s;
      repeat (9) xfer(1'b1, s);
      stop();
   endtask
endmodule // bus_master_model

//--- tb/testbench.sv
// Self-checking bench for the sensor two-wire command port
`timescale 1ns/10ps
module testbench;
   localparam int unsigned BASE = 8;

   logic                    core_clk;
   logic                    resetn;
   logic                    scl;
   wire logic               sda;
   logic                    m_low;
   logic                    sda_out;
   logic                    sda_oe;
   logic                    asp;
   sensor_i2c_pkg::sample_t samples;
   logic [127:0]            prom;
   logic                    conv_busy;
   logic [8:0]              res;
   logic                    res_valid;
   logic [8:0]              exp_q[$];
   integer                  mismatches = 0;
   integer                  checked = 0;
   integer                  seed = 86307;
   integer                  busy_cnt = 0;
   logic [23:0]             pick;
   logic [7:0]              c;

   // Pull-up on the data wire
   assign sda = (m_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

   sensor_i2c_command_port #(.CONV_BASE_CYCLES(BASE)) uut (
      .core_clk(core_clk), .resetn(resetn), .scl(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(asp),
      .samples(samples), .prom_image(prom), .conv_busy(conv_busy));

   bus_master_model m (.scl(scl), .sda(sda), .sda_low(m_low),
      .res(res), .res_valid(res_valid));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
      if (conv_busy === 1'b1) busy_cnt <= busy_cnt + 1;

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (exp_q.size() != 0) mismatches++;
      if (mismatches == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge res_valid) begin
      if (exp_q.size() == 0) begin
         mismatches++;
      end else begin
         check({15'h0000, res}, {15'h0000, exp_q.pop_front()});
      end
   end

   function automatic logic [7:0] addr(input logic rd);
      return {sensor_i2c_pkg::ADDR_PREFIX, ~asp, rd};
   endfunction

   task automatic cmd(input logic [7:0] cb);
      @(posedge core_clk);
      #2 exp_q.push_back(9'h100);
      exp_q.push_back(9'h100);
      m.start();
      m.put_byte(addr(1'b0));
      m.put_byte(cb);
      m.stop();
   endtask

   // Read n bytes, expecting the word exp upper byte first
   task automatic rd(input int n, input logic [23:0] exp);
      @(posedge core_clk);
      #2 exp_q.push_back(9'h100);
      for (int i = n - 1; i >= 0; i--) begin
         exp_q.push_back({1'b0, exp[8*i +: 8]});
      end
      m.start();
      m.put_byte(addr(1'b1));
      for (int i = 0; i < n; i++) begin
         m.get_byte(i == n - 1);
      end
      m.stop();
   endtask

   task automatic wait_conv();
      int i;
      for (i = 0; i < 20000 && !(busy_cnt > 0 && conv_busy === 1'b0); i++)
      begin
         @(posedge core_clk);
         #1;
      end
      if (i == 20000) begin
         mismatches++;
         end_of_test();
      end
   endtask

   initial begin
      resetn  = 1'b0;
      asp     = 1'b0;
      samples = sensor_i2c_pkg::sample_t'(48'({$random(seed), $random(seed)}));
      prom    = {$random(seed), $random(seed), $random(seed), $random(seed)};
      repeat (5) @(posedge core_clk);
      #2 resetn = 1'b1;
      repeat (3) @(posedge core_clk);
      m.recover();
      cmd(sensor_i2c_pkg::CMD_RESET);
      rd(3, 24'h000000);
      cmd(8'hff);
      for (int k = 0; k < 10; k++) begin
         samples = sensor_i2c_pkg::sample_t'(48'({$random(seed),
            $random(seed)}));
         c = 8'h40 | 8'((k / 5) << 4) | 8'((k % 5) << 1);
         pick = (k >= 5) ? samples.temperature : samples.pressure;
         busy_cnt = 0;
         cmd(c);
         wait_conv();
         check(24'(busy_cnt), 24'(BASE << (k % 5)));
         cmd(sensor_i2c_pkg::CMD_ADC_READ);
         rd(3, pick);
         cmd(sensor_i2c_pkg::CMD_ADC_READ);
         rd(3, 24'h000000);
      end
      // Read during a conversion spoils its result
      busy_cnt = 0;
      cmd(8'h48);
      cmd(sensor_i2c_pkg::CMD_ADC_READ);
      rd(3, 24'h000000);
      wait_conv();
      cmd(sensor_i2c_pkg::CMD_ADC_READ);
      rd(3, samples.pressure ^ sensor_i2c_pkg::CORRUPT_MASK);
      // Reset aborts a conversion and reloads the memory
      busy_cnt = 0;
      cmd(8'h58);
      prom = {$random(seed), $random(seed), $random(seed), $random(seed)};
      cmd(sensor_i2c_pkg::CMD_RESET);
      check({23'h000000, conv_busy}, 24'h000000);
      cmd(sensor_i2c_pkg::CMD_ADC_READ);
      rd(3, 24'h000000);
      for (int n = 0; n < 8; n++) begin
         cmd(8'ha0 | 8'(n << 1));
         rd(2, {8'h00, prom[16*n +: 16]});
      end
      // Other select level: old address is foreign
      asp = 1'b1;
      m.recover();
      @(posedge core_clk);
      #2 exp_q.push_back(9'h101);
      m.start();
      m.put_byte({sensor_i2c_pkg::ADDR_PREFIX, 1'b1, 1'b0});
      m.stop();
      cmd(8'ha6);
      rd(2, {8'h00, prom[48 +: 16]});
      repeat (20) @(posedge core_clk);
      end_of_test();
   end
endmodule // testbench
